// ===== design/uls_pkg.sv
// Package for the receive line status block: offsets, fields, types.
package uls_pkg;

    // ========================================================
    // Register map
    localparam logic [2:0] ULS_ADDR_STATUS = 3'h0; // line_status_reg
    localparam logic [2:0] ULS_ADDR_CTRL = 3'h1;   // control
    localparam logic [2:0] ULS_ADDR_DATA = 3'h2;   // receive data pop
    localparam logic [2:0] ULS_ADDR_DIV = 3'h3;    // bit period divisor

    // ========================================================
    // Status bit positions
    localparam int ULS_BIT_READY = 0;
    localparam int ULS_BIT_OVERRUN = 1;
    localparam int ULS_BIT_PARITY = 2;
    localparam int ULS_BIT_FRAMING = 3;
    localparam int ULS_BIT_BREAK = 4;
    localparam int ULS_BIT_FIFO_ERR = 7;

    // Control bit positions
    localparam int ULS_CTL_FIFO_EN = 0;
    localparam int ULS_CTL_PAR_EN = 1;
    localparam int ULS_CTL_PAR_EVEN = 2;

    // ========================================================
    // Reset values
    localparam logic [7:0] ULS_STATUS_RST = 8'h00;
    localparam logic [7:0] ULS_CTRL_RST = 8'h00;
    localparam logic [7:0] ULS_DIV_RST = 8'h10;
    localparam logic [7:0] ULS_BYTE_ZERO = 8'h00;

    // ========================================================
    // Character plus its own error flags, as stored per FIFO entry
    typedef struct packed {
        logic brk;
        logic framing;
        logic parity;
        logic [7:0] data;
    } uls_char_s;

    localparam int ULS_CHAR_W = 11;

    // Receiver states
    typedef enum logic [4:0] {
        ULS_IDLE = 5'h01,
        ULS_START = 5'h02,
        ULS_DATA = 5'h04,
        ULS_PAR = 5'h08,
        ULS_STOP = 5'h10
    } uls_state_e;

endpackage : uls_pkg

// ===== design/uls_char_fifo.sv
// Receive FIFO holding characters with their per-character error flags.
module uls_char_fifo #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic clear_in,
    input wire logic push_in,
    input wire uls_pkg::uls_char_s push_char_in,
    input wire logic pop_in,
    output uls_pkg::uls_char_s head_out,
    output logic [AW:0] count_out,
    output logic full_out,
    output logic [AW:0] err_count_out
);

    // ========================================================
    // Storage
    uls_pkg::uls_char_s mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [AW:0] err_count_reg;
    logic do_push;
    logic do_pop;
    logic push_err;
    logic pop_err;

    // Push refused when full; the caller flags overrun instead
    assign do_push = push_in && (count_reg != DEPTH[AW:0]);
    assign do_pop = pop_in && (count_reg != '0);
    assign push_err = push_char_in.brk | push_char_in.framing
        | push_char_in.parity;
    assign pop_err = mem[rd_ptr_reg].brk | mem[rd_ptr_reg].framing
        | mem[rd_ptr_reg].parity;

    // Entry write
    always_ff @(posedge mclk_in)
    begin
        if (do_push)
        begin
            mem[wr_ptr_reg] <= push_char_in;
        end
    end

    // Pointers and counts
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            err_count_reg <= '0;
        end
        else if (clear_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            err_count_reg <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + {{AW{1'b0}}, do_push}
                - {{AW{1'b0}}, do_pop};
            // Errored entries counted so the summary flag needs no scan
            err_count_reg <= err_count_reg
                + {{AW{1'b0}}, do_push & push_err}
                - {{AW{1'b0}}, do_pop & pop_err};
        end
    end

    assign head_out = mem[rd_ptr_reg];
    assign count_out = count_reg;
    assign full_out = (count_reg == DEPTH[AW:0]);
    assign err_count_out = err_count_reg;

endmodule : uls_char_fifo

// ===== design/uls_line_status.sv
// Receive line status: serial receiver, error flags and status register.
//
// Operation
// - Break flagged when receive line stays low a whole character frame.
// - FIFO mode: one break character stored, however long the line low.
// - Status bit 3 reports missing stop bit as framing error.
// - FIFO mode: framing flag describes the FIFO head character.
// - Status bit 2 reports received parity mismatch against configured parity.
// - FIFO mode: parity flag follows the FIFO head character.
// - Status bit 1 reports overrun: character completes while FIFO or holding register full.
// - FIFO mode overrun: shifter overwritten, nothing pushed, FIFO contents kept.
// - Status bit 0 high while any received character is held.
// - Overrun, parity, framing, ready all zero after reset.
// - Bit 7 set while any FIFO character carries an error flag.
module uls_line_status #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic rx_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic data_ready_out,
    output logic fifo_error_out
);

    // ========================================================
    // Declarations
    uls_pkg::uls_state_e state_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] div_reg;
    logic [7:0] tick_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic par_bit_reg;
    logic all_zero_reg;
    logic break_latched_reg;
    logic overrun_reg;
    logic push_reg;
    uls_pkg::uls_char_s push_char_reg;
    uls_pkg::uls_char_s hold_reg;
    logic hold_valid_reg;
    logic fifo_mode;
    logic half_tick;
    logic full_tick;
    logic pop;
    logic status_rd;
    logic ctrl_wr;
    logic mode_change;
    logic char_done;
    logic stop_ok;
    logic parity_bad;
    logic is_break;
    uls_pkg::uls_char_s done_char;
    uls_pkg::uls_char_s head;
    logic [AW:0] count;
    logic [AW:0] err_count;
    logic fifo_full;
    logic ready;
    logic fifo_err;
    logic [7:0] status;

    // ========================================================
    // Bus decode
    assign status_rd = rd_in && (addr_in == uls_pkg::ULS_ADDR_STATUS);
    assign pop = rd_in && (addr_in == uls_pkg::ULS_ADDR_DATA);
    assign ctrl_wr = wr_in && (addr_in == uls_pkg::ULS_ADDR_CTRL);
    assign mode_change = ctrl_wr && (wdata_in[uls_pkg::ULS_CTL_FIFO_EN]
        != ctrl_reg[uls_pkg::ULS_CTL_FIFO_EN]);
    assign fifo_mode = ctrl_reg[uls_pkg::ULS_CTL_FIFO_EN];

    // Control and divisor registers
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_reg <= uls_pkg::ULS_CTRL_RST;
            div_reg <= uls_pkg::ULS_DIV_RST;
        end
        else if (wr_in)
        begin
            if (addr_in == uls_pkg::ULS_ADDR_CTRL)
            begin
                ctrl_reg <= wdata_in;
            end
            if (addr_in == uls_pkg::ULS_ADDR_DIV)
            begin
                div_reg <= wdata_in;
            end
        end
    end

    // ========================================================
    // Bit timing: div_reg clocks per bit, start, data and parity sampled at mid-bit
    assign half_tick = (tick_reg == {1'b0, div_reg[7:1]});
    assign full_tick = (tick_reg == div_reg - 8'h01);
    assign stop_ok = rx_in;
    assign parity_bad = ctrl_reg[uls_pkg::ULS_CTL_PAR_EN]
        && ((^shift_reg ^ par_bit_reg)
        != !ctrl_reg[uls_pkg::ULS_CTL_PAR_EVEN]);
    // Whole frame low, stop bit included, is a break
    assign is_break = all_zero_reg && !rx_in;
    assign char_done = (state_reg == uls_pkg::ULS_STOP) && half_tick;
    assign done_char = '{brk: is_break, framing: !stop_ok,
        parity: parity_bad, data: shift_reg};

    // Receive state machine
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_reg <= uls_pkg::ULS_IDLE;
            tick_reg <= uls_pkg::ULS_BYTE_ZERO;
            bit_cnt_reg <= 4'h0;
            shift_reg <= uls_pkg::ULS_BYTE_ZERO;
            par_bit_reg <= 1'b0;
            all_zero_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= full_tick ? uls_pkg::ULS_BYTE_ZERO
                : tick_reg + 8'h01;
            unique case (state_reg)
                uls_pkg::ULS_IDLE:
                begin
                    tick_reg <= uls_pkg::ULS_BYTE_ZERO;
                    // Held-low line after a break starts nothing
                    if (!rx_in && !break_latched_reg)
                    begin
                        state_reg <= uls_pkg::ULS_START;
                    end
                end
                uls_pkg::ULS_START:
                begin
                    if (half_tick)
                    begin
                        // Glitch shorter than half a bit is ignored
                        state_reg <= rx_in ? uls_pkg::ULS_IDLE
                            : uls_pkg::ULS_DATA;
                        tick_reg <= uls_pkg::ULS_BYTE_ZERO;
                        bit_cnt_reg <= 4'h0;
                        all_zero_reg <= 1'b1;
                    end
                end
                uls_pkg::ULS_DATA:
                begin
                    if (full_tick)
                    begin
                        shift_reg <= {rx_in, shift_reg[7:1]};
                        all_zero_reg <= all_zero_reg & !rx_in;
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'h7)
                        begin
                            state_reg <= ctrl_reg[uls_pkg::ULS_CTL_PAR_EN]
                                ? uls_pkg::ULS_PAR : uls_pkg::ULS_STOP;
                        end
                    end
                end
                uls_pkg::ULS_PAR:
                begin
                    if (full_tick)
                    begin
                        par_bit_reg <= rx_in;
                        all_zero_reg <= all_zero_reg & !rx_in;
                        state_reg <= uls_pkg::ULS_STOP;
                    end
                end
                uls_pkg::ULS_STOP:
                begin
                    // Stop sampled half a bit early: its half tick lands
                    // half a bit after the last data or parity bit's sample point
                    if (half_tick)
                    begin
                        state_reg <= uls_pkg::ULS_IDLE;
                    end
                end
            endcase
        end
    end

    // Break latch held until the line returns high
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            break_latched_reg <= 1'b0;
        end
        else if (char_done && is_break)
        begin
            break_latched_reg <= 1'b1;
        end
        else if (rx_in)
        begin
            break_latched_reg <= 1'b0;
        end
    end

    // ========================================================
    // Character hand-off: push to FIFO or load holding register
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            push_reg <= 1'b0;
            push_char_reg <= '0;
        end
        else
        begin
            // Full FIFO: character dropped, stored entries untouched
            push_reg <= char_done && fifo_mode && !fifo_full;
            push_char_reg <= done_char;
        end
    end

    // Non-FIFO mode: single holding register, newest character wins
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            hold_reg <= '0;
            hold_valid_reg <= 1'b0;
        end
        else if (mode_change)
        begin
            hold_valid_reg <= 1'b0;
        end
        else if (char_done && !fifo_mode)
        begin
            hold_reg <= done_char;
            hold_valid_reg <= 1'b1;
        end
        else if (pop && !fifo_mode)
        begin
            hold_valid_reg <= 1'b0;
        end
    end

    uls_char_fifo #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .clear_in(mode_change),
        .push_in(push_reg),
        .push_char_in(push_char_reg),
        .pop_in(pop && fifo_mode),
        .head_out(head),
        .count_out(count),
        .full_out(fifo_full),
        .err_count_out(err_count)
    );

    // ========================================================
    // Overrun flag: event set wins over a same-cycle read clear
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            overrun_reg <= 1'b0;
        end
        // Character completes with no room left
        else if (char_done && ((fifo_mode && fifo_full)
            || (!fifo_mode && hold_valid_reg)))
        begin
            overrun_reg <= 1'b1;
        end
        else if (status_rd)
        begin
            overrun_reg <= 1'b0;
        end
    end

    // ========================================================
    // Status assembly
    // Ready while any character held
    assign ready = fifo_mode ? (count != '0) : hold_valid_reg;
    // Any errored entry still in the FIFO
    assign fifo_err = fifo_mode && (err_count != '0);

    always_comb
    begin
        status = uls_pkg::ULS_STATUS_RST;
        status[uls_pkg::ULS_BIT_READY] = ready;
        status[uls_pkg::ULS_BIT_OVERRUN] = overrun_reg;
        // Head entry's own flags, so they track pops
        if (fifo_mode)
        begin
            status[uls_pkg::ULS_BIT_PARITY] = ready && head.parity;
            status[uls_pkg::ULS_BIT_FRAMING] = ready && head.framing;
            status[uls_pkg::ULS_BIT_BREAK] = ready && head.brk;
        end
        else
        begin
            status[uls_pkg::ULS_BIT_PARITY] = ready && hold_reg.parity;
            status[uls_pkg::ULS_BIT_FRAMING] = ready && hold_reg.framing;
            status[uls_pkg::ULS_BIT_BREAK] = ready && hold_reg.brk;
        end
        status[uls_pkg::ULS_BIT_FIFO_ERR] = fifo_err;
    end

    // ========================================================
    // Read data and status outputs, all registered
    // All three outputs zero out of reset
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rdata_out <= uls_pkg::ULS_BYTE_ZERO;
            data_ready_out <= 1'b0;
            fifo_error_out <= 1'b0;
        end
        else
        begin
            data_ready_out <= ready;
            fifo_error_out <= fifo_err;
            rdata_out <= uls_pkg::ULS_BYTE_ZERO;
            if (rd_in)
            begin
                unique case (addr_in)
                    uls_pkg::ULS_ADDR_STATUS: rdata_out <= status;
                    uls_pkg::ULS_ADDR_CTRL: rdata_out <= ctrl_reg;
                    uls_pkg::ULS_ADDR_DATA: rdata_out <= fifo_mode
                        ? head.data : hold_reg.data;
                    uls_pkg::ULS_ADDR_DIV: rdata_out <= div_reg;
                    default: rdata_out <= uls_pkg::ULS_BYTE_ZERO;
                endcase
            end
        end
    end

endmodule : uls_line_status

// ===== tb/uls_tx_model.sv
// Serial transmitter model that drives the block's receive line.
module uls_tx_model #(
    parameter int BIT_CLKS = 8
) (
    input wire logic mclk_in,
    output logic tx_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Line idles high from time zero
    initial tx_out = 1'b1;

    // ========================================================
    // Bit and frame drivers
    task automatic put_bit(input logic v);
        tx_out <= v;
        repeat (BIT_CLKS) @(posedge mclk_in);
    endtask : put_bit

    // One idle bit follows each frame so a low stop never masks a start
    task automatic send(input logic [7:0] b, input logic par_on,
        input logic par_even, input logic bad_par, input logic bad_stop);
        logic p;
        p = (par_even ? ^b : ~^b) ^ bad_par;
        @(posedge mclk_in);
        put_bit(1'b0);
        for (int k = 0; k < 8; k++)
        begin
            put_bit(b[k]); // LSB first
        end
        if (par_on)
        begin
            put_bit(p);
        end
        put_bit(~bad_stop);
        put_bit(1'b1);
    endtask : send

    // Line held low far beyond one frame
    task automatic hold_low(input int n);
        @(posedge mclk_in);
        tx_out <= 1'b0;
        repeat (n) @(posedge mclk_in);
        tx_out <= 1'b1;
    endtask : hold_low
endmodule : uls_tx_model

// ===== tb/uls_line_status_monitor.sv
// Concurrent checks on the ports of the receive line status block.
module uls_line_status_monitor (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic rx_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic data_ready_out,
    input wire logic fifo_error_out
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    // Decoded bus requests
    logic st_rd;
    logic pop_or_flush;
    assign st_rd = rd_in && (addr_in == uls_pkg::ULS_ADDR_STATUS);
    assign pop_or_flush = (rd_in && (addr_in == uls_pkg::ULS_ADDR_DATA))
        || (wr_in && (addr_in == uls_pkg::ULS_ADDR_CTRL));

    // ========================================================
    // Assertions
    a_read_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_reset_flags_clear: assert property ($rose(reset_n_in) |->
        !data_ready_out && !fifo_error_out)
        else $error("flags set right after reset");
    a_ready_bit_match: assert property (st_rd |=>
        rdata_out[0] == data_ready_out)
        else $error("ready output differs from status bit 0");
    a_fifo_err_match: assert property (st_rd |=>
        rdata_out[7] == fifo_error_out)
        else $error("error output differs from status bit 7");
    a_unused_bits_zero: assert property (st_rd |=> rdata_out[6:5] == 2'h0)
        else $error("status bits 6 and 5 not zero");
    a_flags_need_char: assert property (st_rd |=>
        (rdata_out[4:2] == 3'h0) || rdata_out[0])
        else $error("character flag set with nothing held");
    a_error_needs_data: assert property (fifo_error_out |->
        data_ready_out)
        else $error("fifo error without held data");
    a_ready_fall_cause: assert property ($fell(data_ready_out) |->
        $past(pop_or_flush, 1) || $past(pop_or_flush, 2)
        || $past(pop_or_flush, 3))
        else $error("ready dropped without pop");
    a_unmapped_reads_zero: assert property (rd_in && addr_in[2] |=>
        rdata_out == 8'h00)
        else $error("unmapped read not zero");

    // Main scenarios reached
    c_overrun_seen: cover property (st_rd ##1 rdata_out[1]);
    c_break_seen: cover property (st_rd ##1 rdata_out[4]);
    c_fifo_err_rise: cover property ($rose(fifo_error_out));
    c_fifo_mode_on: cover property (wr_in
        && (addr_in == uls_pkg::ULS_ADDR_CTRL)
        && wdata_in[uls_pkg::ULS_CTL_FIFO_EN]);
    c_line_start: cover property ($fell(rx_in));
endmodule : uls_line_status_monitor

// ===== tb/tb.sv
// Self-checking bench for the receive line status block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BIT_CLKS = 8;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    wire logic rx_line;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic data_ready_out;
    logic fifo_error_out;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;

    // 10 MHz clock
    always #50 mclk_in = ~mclk_in;

    // Small FIFO so it fills in a few frames
    uls_line_status #(.DEPTH(4), .AW(2)) dut_u (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .rx_in(rx_line),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out),
        .data_ready_out(data_ready_out), .fifo_error_out(fifo_error_out));

    uls_tx_model #(.BIT_CLKS(BIT_CLKS)) tx_u (
        .mclk_in(mclk_in), .tx_out(rx_line));

    // ========================================================
    // Bus tasks and comparison
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr

    // Read data taken only in the single answer cycle
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp,
        input logic [7:0] msk = 8'hFF);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out & msk, exp);
    endtask : rdc

    task automatic settle();
        repeat (4) @(posedge mclk_in);
    endtask : settle

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // Cuts a hang short; the full run needs about 1700 cycles
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            err_count++;
            stop_test();
        end
    end

    // ========================================================
    // Test sequence
    initial
    begin
        repeat (5) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        // Reset values, read-only and unmapped places
        rdc(uls_pkg::ULS_ADDR_STATUS, uls_pkg::ULS_STATUS_RST);
        rdc(uls_pkg::ULS_ADDR_CTRL, uls_pkg::ULS_CTRL_RST);
        rdc(uls_pkg::ULS_ADDR_DIV, uls_pkg::ULS_DIV_RST);
        wr(3'h5, 8'hFF);
        wr(uls_pkg::ULS_ADDR_STATUS, 8'hFF);
        rdc(3'h5, 8'h00);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h00);
        wr(uls_pkg::ULS_ADDR_DIV, BIT_CLKS[7:0]);
        $display("test reset done");

        // Holding register: plain char, then framing error
        tx_u.send(8'hA5, 1'b0, 1'b0, 1'b0, 1'b0);
        settle();
        chk({7'h00, data_ready_out}, 8'h01);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h01);
        rdc(uls_pkg::ULS_ADDR_DATA, 8'hA5);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h00);
        tx_u.send(8'h3C, 1'b0, 1'b0, 1'b0, 1'b1);
        settle();
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h09);
        rdc(uls_pkg::ULS_ADDR_DATA, 8'h3C);
        $display("test holding done");

        // Both parity senses, good and bad
        for (int m = 0; m < 4; m++)
        begin
            // Holding mode with parity on; bit 2 picks the sense
            wr(uls_pkg::ULS_ADDR_CTRL, {5'h00, m[1], 2'h2});
            tx_u.send(8'h11, 1'b1, m[1], m[0], 1'b0);
            settle();
            rdc(uls_pkg::ULS_ADDR_STATUS, {5'h00, m[0], 2'h1});
            rdc(uls_pkg::ULS_ADDR_DATA, 8'h11);
        end
        $display("test parity done");

        // Holding register overrun, then status read clears it
        wr(uls_pkg::ULS_ADDR_CTRL, 8'h00);
        tx_u.send(8'h5A, 1'b0, 1'b0, 1'b0, 1'b0);
        tx_u.send(8'hC3, 1'b0, 1'b0, 1'b0, 1'b0);
        settle();
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h03);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h01);
        rdc(uls_pkg::ULS_ADDR_DATA, 8'hC3);
        $display("test overrun done");

        // FIFO mode, even parity: fill with mixed errors, then overflow
        wr(uls_pkg::ULS_ADDR_CTRL, 8'h07);
        tx_u.send(8'h01, 1'b1, 1'b1, 1'b0, 1'b0);
        tx_u.send(8'h02, 1'b1, 1'b1, 1'b1, 1'b0);
        tx_u.send(8'h03, 1'b1, 1'b1, 1'b0, 1'b1);
        tx_u.send(8'h04, 1'b1, 1'b1, 1'b0, 1'b0);
        tx_u.send(8'h05, 1'b1, 1'b1, 1'b0, 1'b0);
        settle();
        chk({7'h00, fifo_error_out}, 8'h01);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h83);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h81);
        rdc(uls_pkg::ULS_ADDR_DATA, 8'h01);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h85);
        rdc(uls_pkg::ULS_ADDR_DATA, 8'h02);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h89);
        rdc(uls_pkg::ULS_ADDR_DATA, 8'h03);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h01);
        rdc(uls_pkg::ULS_ADDR_DATA, 8'h04);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h00);
        $display("test fifo done");

        // Line low for about three frames gives one break char only
        tx_u.hold_low(300);
        repeat (3 * BIT_CLKS) @(posedge mclk_in);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h91, 8'h93);
        rdc(uls_pkg::ULS_ADDR_DATA, 8'h00);
        rdc(uls_pkg::ULS_ADDR_STATUS, 8'h00);
        $display("test break done");
        stop_test();
    end
endmodule : tb

bind uls_line_status uls_line_status_monitor mon_u (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .rx_in(rx_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out),
    .data_ready_out(data_ready_out), .fifo_error_out(fifo_error_out));
